// [design/mcsmp_pkg.sv]
`default_nettype none

package mcsmp_pkg;

  // ----------------------------------------------------------------
  // bus shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  typedef logic [ADDR_W-1:0] mcsmp_addr_t;
  typedef logic [DATA_W-1:0] mcsmp_data_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    mcsmp_addr_t addr;
    mcsmp_data_t wdata;
  } mcsmp_bus_t;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam mcsmp_addr_t CLK_MODE_A_ADDR  = 5'h00;
  localparam mcsmp_addr_t CLK_MODE_B_ADDR  = 5'h01;
  localparam mcsmp_addr_t CLK_MODE_C_ADDR  = 5'h02;
  localparam mcsmp_addr_t PLL_CTRL_ADDR    = 5'h03;
  localparam mcsmp_addr_t PERIPH_CLK_ADDR  = 5'h04;
  localparam mcsmp_addr_t CAN_CLK_ADDR     = 5'h05;
  localparam mcsmp_addr_t PROC_MODE_A_ADDR = 5'h06;
  localparam mcsmp_addr_t PROC_MODE_B_ADDR = 5'h07;
  localparam mcsmp_addr_t PROC_MODE_C_ADDR = 5'h08;
  localparam mcsmp_addr_t TIMER_B2_ADDR    = 5'h09;
  localparam mcsmp_addr_t INV_CTRL_A_ADDR  = 5'h0A;
  localparam mcsmp_addr_t INV_CTRL_B_ADDR  = 5'h0B;
  localparam mcsmp_addr_t PORT7_DIR_ADDR   = 5'h0C;
  localparam mcsmp_addr_t PORT9_DIR_ADDR   = 5'h0D;
  localparam mcsmp_addr_t SERIAL3_ADDR     = 5'h0E;
  localparam mcsmp_addr_t SERIAL4_ADDR     = 5'h0F;
  localparam mcsmp_addr_t SERIAL5_ADDR     = 5'h10;
  localparam mcsmp_addr_t SERIAL6_ADDR     = 5'h11;
  localparam mcsmp_addr_t PROTECT_ADDR     = 5'h12;
  localparam int          NUM_REGS         = 18;

  localparam mcsmp_data_t REG_RESET        = 8'h00;
  localparam logic [2:0]  PROTECT_RESET    = 3'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int WAIT_PERIPH_STOP_BIT = 2;
  localparam int MAIN_CLK_STOP_BIT    = 5;
  localparam int SUB_CLK_SELECT_BIT   = 7;
  localparam int OSC_DET_ENABLE_BIT   = 0;
  localparam int OSC_SRC_SELECT_BIT   = 1;
  localparam int DETECTED_FLAG_BIT    = 2;
  localparam int MAIN_STOPPED_BIT     = 3;
  localparam int DET_ACTION_BIT       = 7;
  localparam int PLL_SELECT_BIT       = 7;
  localparam int CLOCK_PROTECT_BIT    = 0;
  localparam int MODE_PROTECT_BIT     = 1;
  localparam int PORT_PROTECT_BIT     = 2;
  localparam mcsmp_data_t CLK_MODE_C_SW_MASK = 8'h83;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int STOP_TIMEOUT_NS  = 1000;
  localparam int STOP_TIMEOUT_CYC = (STOP_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {CPU_MAIN, CPU_PLL, CPU_SUB, CPU_ONCHIP} mcsmp_cpu_src_t;

  // protect bit that must be 1 for a write to land, none for open registers
  function automatic logic [2:0] guardOf(input mcsmp_addr_t addr);
    guardOf = 3'h0;
    if (addr <= CAN_CLK_ADDR) guardOf = 3'h1;
    else if (addr <= INV_CTRL_B_ADDR) guardOf = 3'h2;
    else if (addr <= SERIAL6_ADDR) guardOf = 3'h4;
  endfunction

endpackage

`default_nettype wire

// [design/mcsmp_osc_detect.sv]
`default_nettype none

module mcsmp_osc_detect #(
  parameter int TIMEOUT = mcsmp_pkg::STOP_TIMEOUT_CYC
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic oscActivity,
  output var  logic stopEvt_q,
  output var  logic restartEvt_q
);
  import mcsmp_pkg::*;

  localparam int CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT);

  logic          prevAct_q, prevAct_d;
  logic [CW-1:0] idleCnt_q, idleCnt_d;
  logic          stopped_q, stopped_d;
  logic          stopEvt_d, restartEvt_d;
  logic          toggled;

  // ----------------------------------------------------------------
  // idle timer: no toggle for TIMEOUT cycles means the oscillator stopped
  // ----------------------------------------------------------------
  always_comb begin
    toggled   = oscActivity ^ prevAct_q;
    prevAct_d = oscActivity;
    idleCnt_d = idleCnt_q;
    if (toggled) begin
      idleCnt_d = '0;
    end else if (idleCnt_q != LIMIT) begin
      idleCnt_d = idleCnt_q + CW'(1);
    end
    stopped_d    = toggled ? 1'b0 : ((idleCnt_d == LIMIT) ? 1'b1 : stopped_q);
    stopEvt_d    = stopped_d & ~stopped_q;
    restartEvt_d = ~stopped_d & stopped_q;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prevAct_q    <= 1'b0;
      idleCnt_q    <= '0;
      stopped_q    <= 1'b0;
      stopEvt_q    <= 1'b0;
      restartEvt_q <= 1'b0;
    end else begin
      prevAct_q    <= prevAct_d;
      idleCnt_q    <= idleCnt_d;
      stopped_q    <= stopped_d;
      stopEvt_q    <= stopEvt_d;
      restartEvt_q <= restartEvt_d;
    end
  end

endmodule // mcsmp_osc_detect

`default_nettype wire

// [design/mcsmp_protect.sv]
`default_nettype none

module mcsmp_protect (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire mcsmp_pkg::mcsmp_bus_t  bus,
  output var  logic [2:0]             prot_q
);
  import mcsmp_pkg::*;

  logic [2:0] prot_d;

  // ----------------------------------------------------------------
  // write protect control
  // ----------------------------------------------------------------
  always_comb begin
    prot_d = prot_q;
    if (bus.wr && bus.addr == PROTECT_ADDR) begin
      prot_d = bus.wdata[2:0];
    end else if (bus.wr) begin
      prot_d[PORT_PROTECT_BIT] = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prot_q <= PROTECT_RESET;
    end else begin
      prot_q <= prot_d;
    end
  end

  port_serial_protect_bit_auto_a: assert property (@(posedge mclk) disable iff (sys_rst)
    bus.wr && bus.addr != PROTECT_ADDR |=> !prot_q[PORT_PROTECT_BIT])
    else $error("port protect bit survived a write");

  prc01_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !(bus.wr && bus.addr == PROTECT_ADDR) |=> prot_q[1:0] == $past(prot_q[1:0]))
    else $error("clock or mode protect bit changed without a write");

endmodule // mcsmp_protect

`default_nettype wire

// [design/mcsmp_clock_monitor.sv]
// Contract
// - detect action select: 0 requests a device reset, 1 requests the detection interrupt.
// - no detection action of any kind while detection enable is 0.
// - main-source halt in interrupt mode: interrupt, start on-chip oscillator, switch CPU and peripherals.
// - that halt sets source select, detected flag and stopped status to 1.
// - PLL-source halt: interrupt, detected and stopped set, source select left for software.
// - restart: interrupt, detected flag 1, stopped status 0, source select unchanged.
// - detection interrupt shares the watchdog request line; software reads detected flag.
// - detected flag set with the request; while 1 further requests blocked; write 0 re-enables.
// - halt in low speed mode: CPU stays on sub clock, peripherals move to on-chip.
// - clock protect bit guards the clock mode, PLL and prescaler registers.
// - mode protect bit guards processor mode, timer B2 special and inverter registers.
// - port protect bit guards port 7/9 direction and serial 3 to 6 control.
// - port protect bit returns to 0 on the next write to any address other than the protect register.
// - clock and mode protect bits change only by explicit software write.
`default_nettype none

module mcsmp_clock_monitor #(
  parameter int STOP_TIMEOUT = mcsmp_pkg::STOP_TIMEOUT_CYC
) (
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  input  wire mcsmp_pkg::mcsmp_bus_t     bus,
  output var  mcsmp_pkg::mcsmp_data_t    rdData_q,
  input  wire logic                      oscActivity,
  input  wire logic                      watchdogReq,
  output var  logic                      sharedNmiReq_q,
  output var  logic                      detectIrq_q,
  output var  logic                      oscResetReq_q,
  output var  mcsmp_pkg::mcsmp_cpu_src_t cpuClkSrc_q,
  output var  logic                      periphOnChip_q,
  output var  logic                      mainClkStop_q,
  output var  logic                      waitPeriphStop_q
);
  import mcsmp_pkg::*;

  mcsmp_data_t    regs_q [NUM_REGS];
  mcsmp_data_t    regs_d [NUM_REGS];
  logic [2:0]     prot_q;
  logic           stopEvt, restartEvt;
  logic           lowFallback_q, lowFallback_d;
  logic           detectIrq_d, oscResetReq_d, sharedNmiReq_d;
  mcsmp_data_t    rdData_d;
  mcsmp_cpu_src_t cpuClkSrc_d;
  logic           periphOnChip_d;
  logic           wrAllowed;
  logic           detEnable, actionIrq, flagSet, lowSpeed, pllSel, srcSel;
  logic           accepted, stopTaken, restartTaken;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  mcsmp_osc_detect #(
    .TIMEOUT (STOP_TIMEOUT)
  ) u_detect (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .oscActivity  (oscActivity),
    .stopEvt_q    (stopEvt),
    .restartEvt_q (restartEvt)
  );

  mcsmp_protect u_protect (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .bus     (bus),
    .prot_q  (prot_q)
  );

  // ----------------------------------------------------------------
  // decode of current settings
  // ----------------------------------------------------------------
  always_comb begin
    detEnable = regs_q[CLK_MODE_C_ADDR][OSC_DET_ENABLE_BIT];
    actionIrq = regs_q[CLK_MODE_C_ADDR][DET_ACTION_BIT];
    flagSet   = regs_q[CLK_MODE_C_ADDR][DETECTED_FLAG_BIT];
    srcSel    = regs_q[CLK_MODE_C_ADDR][OSC_SRC_SELECT_BIT];
    lowSpeed  = regs_q[CLK_MODE_A_ADDR][SUB_CLK_SELECT_BIT];
    pllSel    = regs_q[PLL_CTRL_ADDR][PLL_SELECT_BIT];
    wrAllowed = bus.wr && bus.addr < PROTECT_ADDR &&
                (guardOf(bus.addr) == 3'h0 || (guardOf(bus.addr) & prot_q) != 3'h0);
    accepted     = detEnable && (stopEvt || restartEvt);
    stopTaken    = accepted && actionIrq && stopEvt;
    restartTaken = accepted && actionIrq && restartEvt;
  end

  // ----------------------------------------------------------------
  // register file and detection state
  // ----------------------------------------------------------------
  always_comb begin
    regs_d        = regs_q;
    lowFallback_d = lowFallback_q;
    if (wrAllowed) begin
      if (bus.addr == CLK_MODE_C_ADDR) begin
        regs_d[CLK_MODE_C_ADDR] = (bus.wdata & CLK_MODE_C_SW_MASK) |
                                  (regs_q[CLK_MODE_C_ADDR] & ~CLK_MODE_C_SW_MASK);
        regs_d[CLK_MODE_C_ADDR][DETECTED_FLAG_BIT] = flagSet & bus.wdata[DETECTED_FLAG_BIT];
        lowFallback_d = 1'b0;
      end else begin
        regs_d[bus.addr] = bus.wdata;
      end
    end
    // hardware updates win over a software write in the same cycle
    if (stopTaken) begin
      regs_d[CLK_MODE_C_ADDR][DETECTED_FLAG_BIT] = 1'b1;
      regs_d[CLK_MODE_C_ADDR][MAIN_STOPPED_BIT]  = 1'b1;
      if (lowSpeed) begin
        lowFallback_d = 1'b1;
      end else if (!pllSel) begin
        regs_d[CLK_MODE_C_ADDR][OSC_SRC_SELECT_BIT] = 1'b1;
      end
    end
    if (restartTaken) begin
      regs_d[CLK_MODE_C_ADDR][DETECTED_FLAG_BIT] = 1'b1;
      regs_d[CLK_MODE_C_ADDR][MAIN_STOPPED_BIT]  = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
      lowFallback_q <= 1'b0;
    end else begin
      regs_q        <= regs_d;
      lowFallback_q <= lowFallback_d;
    end
  end

  // ----------------------------------------------------------------
  // requests, clock routing and read data
  // ----------------------------------------------------------------
  always_comb begin
    detectIrq_d    = (stopTaken || restartTaken) && !flagSet;
    oscResetReq_d  = accepted && !actionIrq;
    sharedNmiReq_d = detectIrq_d || watchdogReq;
    if (regs_d[CLK_MODE_A_ADDR][SUB_CLK_SELECT_BIT]) begin
      cpuClkSrc_d = CPU_SUB;
    end else if (regs_d[CLK_MODE_C_ADDR][OSC_SRC_SELECT_BIT]) begin
      cpuClkSrc_d = CPU_ONCHIP;
    end else if (regs_d[PLL_CTRL_ADDR][PLL_SELECT_BIT]) begin
      cpuClkSrc_d = CPU_PLL;
    end else begin
      cpuClkSrc_d = CPU_MAIN;
    end
    periphOnChip_d = regs_d[CLK_MODE_C_ADDR][OSC_SRC_SELECT_BIT] || lowFallback_d;
    rdData_d = 8'h00;
    if (bus.rd) begin
      if (bus.addr == PROTECT_ADDR) begin
        rdData_d = {5'h00, prot_q};
      end else if (bus.addr < PROTECT_ADDR) begin
        rdData_d = regs_q[bus.addr];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_q         <= 8'h00;
      detectIrq_q      <= 1'b0;
      oscResetReq_q    <= 1'b0;
      sharedNmiReq_q   <= 1'b0;
      cpuClkSrc_q      <= CPU_MAIN;
      periphOnChip_q   <= 1'b0;
      mainClkStop_q    <= 1'b0;
      waitPeriphStop_q <= 1'b0;
    end else begin
      rdData_q         <= rdData_d;
      detectIrq_q      <= detectIrq_d;
      oscResetReq_q    <= oscResetReq_d;
      sharedNmiReq_q   <= sharedNmiReq_d;
      cpuClkSrc_q      <= cpuClkSrc_d;
      periphOnChip_q   <= periphOnChip_d;
      mainClkStop_q    <= regs_d[CLK_MODE_A_ADDR][MAIN_CLK_STOP_BIT];
      waitPeriphStop_q <= regs_d[CLK_MODE_A_ADDR][WAIT_PERIPH_STOP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  reset_mode_a: assert property (@(posedge mclk) disable iff (sys_rst)
    oscResetReq_q |-> $past(!actionIrq) && !detectIrq_q)
    else $error("reset request raised in interrupt mode");

  enable_gates_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (detectIrq_q || oscResetReq_q) |-> $past(detEnable))
    else $error("detection acted while disabled");

  main_stop_switch_a: assert property (@(posedge mclk) disable iff (sys_rst)
    stopTaken && !lowSpeed && !pllSel && !flagSet |=> detectIrq_q && cpuClkSrc_q == CPU_ONCHIP && periphOnChip_q)
    else $error("main clock halt did not fall back to on-chip oscillator");

  stop_flags_a: assert property (@(posedge mclk) disable iff (sys_rst)
    stopTaken && !lowSpeed && !pllSel |=>
      regs_q[CLK_MODE_C_ADDR][OSC_SRC_SELECT_BIT] && regs_q[CLK_MODE_C_ADDR][DETECTED_FLAG_BIT]
      && regs_q[CLK_MODE_C_ADDR][MAIN_STOPPED_BIT])
    else $error("halt flags not set");

  pll_keeps_sel_a: assert property (@(posedge mclk) disable iff (sys_rst)
    stopTaken && pllSel && !lowSpeed && !(bus.wr && bus.addr == CLK_MODE_C_ADDR) |=>
      regs_q[CLK_MODE_C_ADDR][OSC_SRC_SELECT_BIT] == $past(srcSel)
      && regs_q[CLK_MODE_C_ADDR][MAIN_STOPPED_BIT])
    else $error("source select moved on a pll-source halt");

  restart_status_a: assert property (@(posedge mclk) disable iff (sys_rst)
    restartTaken && !(bus.wr && bus.addr == CLK_MODE_C_ADDR) |=>
      !regs_q[CLK_MODE_C_ADDR][MAIN_STOPPED_BIT] && regs_q[CLK_MODE_C_ADDR][DETECTED_FLAG_BIT]
      && regs_q[CLK_MODE_C_ADDR][OSC_SRC_SELECT_BIT] == $past(srcSel))
    else $error("restart status wrong");

  shared_line_a: assert property (@(posedge mclk) disable iff (sys_rst)
    detectIrq_q |-> sharedNmiReq_q)
    else $error("detection request missing on shared line");

  flag_blocks_a: assert property (@(posedge mclk) disable iff (sys_rst)
    detectIrq_q |-> $past(!flagSet) ##1 !detectIrq_q)
    else $error("detection request while flag set");

  low_speed_a: assert property (@(posedge mclk) disable iff (sys_rst)
    stopTaken && lowSpeed && !bus.wr |=> cpuClkSrc_q == CPU_SUB && periphOnChip_q)
    else $error("low speed halt routed clocks wrongly");

  guard_ignore_a: assert property (@(posedge mclk) disable iff (sys_rst)
    bus.wr && bus.addr == PORT7_DIR_ADDR && !prot_q[PORT_PROTECT_BIT] |=>
      regs_q[PORT7_DIR_ADDR] == $past(regs_q[PORT7_DIR_ADDR]))
    else $error("guarded register written while protected");

  // ----------------------------------------------------------------
  // checks: register guards and request routing
  // ----------------------------------------------------------------
  clk_guard_a: assert property (@(posedge mclk) disable iff (sys_rst)
    bus.wr && bus.addr == PLL_CTRL_ADDR && !prot_q[CLOCK_PROTECT_BIT] |=>
      regs_q[PLL_CTRL_ADDR] == $past(regs_q[PLL_CTRL_ADDR]))
    else $error("clock register written while protected");

  clk_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    bus.wr && bus.addr == PERIPH_CLK_ADDR && prot_q[CLOCK_PROTECT_BIT] |=>
      regs_q[PERIPH_CLK_ADDR] == $past(bus.wdata))
    else $error("enabled clock register write lost");

  mode_guard_a: assert property (@(posedge mclk) disable iff (sys_rst)
    bus.wr && bus.addr == PROC_MODE_A_ADDR && !prot_q[MODE_PROTECT_BIT] |=>
      regs_q[PROC_MODE_A_ADDR] == $past(regs_q[PROC_MODE_A_ADDR]))
    else $error("mode register written while protected");

  mode_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    bus.wr && bus.addr == TIMER_B2_ADDR && prot_q[MODE_PROTECT_BIT] |=>
      regs_q[TIMER_B2_ADDR] == $past(bus.wdata))
    else $error("enabled mode register write lost");

  serial_guard_a: assert property (@(posedge mclk) disable iff (sys_rst)
    bus.wr && bus.addr == SERIAL6_ADDR && !prot_q[PORT_PROTECT_BIT] |=>
      regs_q[SERIAL6_ADDR] == $past(regs_q[SERIAL6_ADDR]))
    else $error("serial register written while protected");

  port_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    bus.wr && bus.addr == PORT9_DIR_ADDR && prot_q[PORT_PROTECT_BIT] |=>
      regs_q[PORT9_DIR_ADDR] == $past(bus.wdata))
    else $error("enabled port register write lost");

  stopped_frozen_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !detEnable |=> $stable(regs_q[CLK_MODE_C_ADDR][MAIN_STOPPED_BIT]))
    else $error("stopped status moved while detection disabled");

  irq_no_reset_a: assert property (@(posedge mclk) disable iff (sys_rst)
    accepted && actionIrq |=> !oscResetReq_q)
    else $error("reset request raised in interrupt mode");

  reset_req_a: assert property (@(posedge mclk) disable iff (sys_rst)
    accepted && !actionIrq |=> oscResetReq_q && !detectIrq_q)
    else $error("reset mode event gave no reset request");

  flag_with_req_a: assert property (@(posedge mclk) disable iff (sys_rst)
    detectIrq_q |-> regs_q[CLK_MODE_C_ADDR][DETECTED_FLAG_BIT])
    else $error("detected flag not set with the request");

  restart_irq_a: assert property (@(posedge mclk) disable iff (sys_rst)
    restartTaken && !flagSet |=> detectIrq_q)
    else $error("restart raised no request");

  pll_irq_a: assert property (@(posedge mclk) disable iff (sys_rst)
    stopTaken && pllSel && !lowSpeed && !srcSel && !flagSet && !bus.wr |=>
      detectIrq_q && cpuClkSrc_q == CPU_PLL)
    else $error("pll-source halt routed wrongly");

  watchdog_share_a: assert property (@(posedge mclk) disable iff (sys_rst)
    watchdogReq |=> sharedNmiReq_q)
    else $error("watchdog request missing on shared line");

  stop_irq_c: cover property (@(posedge mclk) disable iff (sys_rst) stopTaken && !flagSet);
  restart_irq_c: cover property (@(posedge mclk) disable iff (sys_rst) restartTaken && !flagSet);
  reset_req_c: cover property (@(posedge mclk) disable iff (sys_rst) oscResetReq_q);
  low_speed_c: cover property (@(posedge mclk) disable iff (sys_rst) stopTaken && lowSpeed);
  pll_halt_c: cover property (@(posedge mclk) disable iff (sys_rst) stopTaken && pllSel);

endmodule // mcsmp_clock_monitor

`default_nettype wire

// [testbench/mcsmp_osc_model.sv]
`default_nettype none

module mcsmp_osc_model (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic runOsc,
  output var  logic oscActivity
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // main oscillator
  // ----------------------------------------------------------------
  // toggles on every rising system clock edge while runOsc is 1, far above the lowest detectable frequency
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      oscActivity <= 1'b0;
    end else if (runOsc) begin
      oscActivity <= ~oscActivity;
    end
  end

endmodule // mcsmp_osc_model

`default_nettype wire

// [testbench/tb.sv]
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcsmp_pkg::*;

  logic           mclk = 1'b0;
  logic           sys_rst = 1'b1;
  mcsmp_bus_t     bus = '0;
  mcsmp_data_t    rdData_q;
  logic           oscActivity;
  logic           runOsc = 1'b1;
  logic           watchdogReq = 1'b0;
  logic           sharedNmiReq_q;
  logic           detectIrq_q;
  logic           oscResetReq_q;
  mcsmp_cpu_src_t cpuClkSrc_q;
  logic           periphOnChip_q;
  logic           mainClkStop_q;
  logic           waitPeriphStop_q;
  int             err_count = 0;
  int             cmp_count = 0;
  int             irqCnt = 0;
  int             rstCnt = 0;
  int             cycles = 0;
  logic [31:0]    seed = 32'h16;
  mcsmp_data_t    expReg [0:17];

  localparam mcsmp_addr_t CMC = CLK_MODE_C_ADDR;

  always #5 mclk = ~mclk;

  mcsmp_clock_monitor #(.STOP_TIMEOUT(4)) mcsmp_clock_monitor_i (
    .mclk(mclk), .sys_rst(sys_rst), .bus(bus), .rdData_q(rdData_q), .oscActivity(oscActivity),
    .watchdogReq(watchdogReq), .sharedNmiReq_q(sharedNmiReq_q), .detectIrq_q(detectIrq_q),
    .oscResetReq_q(oscResetReq_q), .cpuClkSrc_q(cpuClkSrc_q), .periphOnChip_q(periphOnChip_q),
    .mainClkStop_q(mainClkStop_q), .waitPeriphStop_q(waitPeriphStop_q)
  );

  mcsmp_osc_model mcsmp_osc_model_i (
    .mclk(mclk), .sys_rst(sys_rst), .runOsc(runOsc), .oscActivity(oscActivity)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int guardIdx(input int a);
    return (a <= 5) ? 0 : ((a <= 11) ? 1 : 2);
  endfunction

  task automatic wr(input mcsmp_addr_t a, input mcsmp_data_t d);
    @(posedge mclk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input mcsmp_addr_t a, input mcsmp_data_t e);
    @(posedge mclk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 chk(rdData_q, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic waitIrq(input int n);
    for (int i = 0; i < 40 && irqCnt != n; i++) idle(1);
    chk(8'(irqCnt), 8'(n));
  endtask

  task automatic osc(input logic on);
    @(posedge mclk);
    runOsc <= on;
  endtask

  always @(posedge mclk) begin
    cycles++;
    #1;
    if (detectIrq_q === 1'b1) begin
      irqCnt++;
      chk(sharedNmiReq_q, 1'b1);
    end
    if (oscResetReq_q === 1'b1) rstCnt++;
    if (cycles == 20000) begin
      err_count++;
      $display("ERROR %0t: timeout", $time);
      results();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    mcsmp_data_t d;
    int g;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (expReg[a]) expReg[a] = REG_RESET;
    for (int a = 0; a <= 18; a++) rd(5'(a), 8'h00);
    $display("test reset values done");
    for (int a = 0; a < 18; a++) begin
      g = guardIdx(a);
      wr(PROTECT_ADDR, 8'(~(1 << g) & 7));
      wr(5'(a), 8'(xs()));
      rd(5'(a), expReg[a]);
      wr(PROTECT_ADDR, 8'(1 << g));
      d = (a == 2) ? (8'(xs()) & 8'h82) : 8'(xs());
      wr(5'(a), d);
      expReg[a] = d;
      rd(5'(a), d);
      rd(PROTECT_ADDR, (g == 2) ? 8'h00 : 8'(1 << g));
      if (a == 0) chk({waitPeriphStop_q, mainClkStop_q}, {d[2], d[5]});
      wr(PROTECT_ADDR, 8'h00);
    end
    wr(PROTECT_ADDR, 8'h07);
    wr(5'h13, 8'(xs()));
    rd(PROTECT_ADDR, 8'h03);
    rd(5'h13, 8'h00);
    wr(PROTECT_ADDR, 8'h01);
    wr(CLK_MODE_A_ADDR, 8'h00);
    wr(PLL_CTRL_ADDR, 8'h00);
    wr(CMC, 8'h00);
    $display("test protection done");
    osc(1'b0);
    idle(30);
    osc(1'b1);
    idle(20);
    chk(8'(irqCnt + rstCnt), 8'h00);
    rd(CMC, 8'h00);
    wr(CMC, 8'h01);
    osc(1'b0);
    for (int i = 0; i < 40 && rstCnt == 0; i++) idle(1);
    chk(8'(rstCnt), 8'h01);
    chk(8'(irqCnt), 8'h00);
    wr(CMC, 8'h00);
    osc(1'b1);
    idle(20);
    chk(8'(rstCnt), 8'h01);
    $display("test reset mode done");
    wr(CMC, 8'h81);
    osc(1'b0);
    waitIrq(1);
    chk(cpuClkSrc_q, CPU_ONCHIP);
    chk(periphOnChip_q, 1'b1);
    rd(CMC, 8'h8F);
    osc(1'b1);
    idle(20);
    chk(8'(irqCnt), 8'h01);
    rd(CMC, 8'h87);
    wr(CMC, 8'h81);
    rd(CMC, 8'h81);
    chk(cpuClkSrc_q, CPU_MAIN);
    osc(1'b0);
    waitIrq(2);
    wr(CMC, 8'h83);
    osc(1'b1);
    waitIrq(3);
    rd(CMC, 8'h87);
    wr(CMC, 8'h81);
    @(posedge mclk);
    watchdogReq <= 1'b1;
    @(posedge mclk);
    watchdogReq <= 1'b0;
    #1 chk({sharedNmiReq_q, detectIrq_q}, 2'h2);
    rd(CMC, 8'h81);
    $display("test interrupt mode done");
    wr(CMC, 8'h00);
    wr(PLL_CTRL_ADDR, 8'h80);
    wr(CMC, 8'h81);
    chk(cpuClkSrc_q, CPU_PLL);
    osc(1'b0);
    waitIrq(4);
    rd(CMC, 8'h8D);
    chk(cpuClkSrc_q, CPU_PLL);
    wr(CMC, 8'h80);
    osc(1'b1);
    idle(20);
    wr(PLL_CTRL_ADDR, 8'h00);
    $display("test pll source done");
    wr(CLK_MODE_A_ADDR, 8'h80);
    wr(CMC, 8'h81);
    chk(cpuClkSrc_q, CPU_SUB);
    osc(1'b0);
    waitIrq(5);
    chk(cpuClkSrc_q, CPU_SUB);
    chk(periphOnChip_q, 1'b1);
    wr(CMC, 8'h00);
    osc(1'b1);
    idle(20);
    chk(8'(irqCnt), 8'h05);
    $display("test low speed done");
    results();
  end

endmodule // tb

`default_nettype wire
